// ==== design/co2rm_consts.svh ====
// constants for the co2 sensor register bank
`ifndef CO2RM_CONSTS_SVH
`define CO2RM_CONSTS_SVH

// register offsets
`define CO2RM_OFF_RST 8'h00
`define CO2RM_OFF_MODE 8'h01
`define CO2RM_OFF_STAT 8'h02
`define CO2RM_OFF_DLO 8'h03
`define CO2RM_OFF_DHI 8'h04
`define CO2RM_OFF_PRESS 8'h09
`define CO2RM_OFF_ALT 8'h0a
`define CO2RM_OFF_THR_HI 8'h0c
`define CO2RM_OFF_THR_LO 8'h0d
`define CO2RM_OFF_FEAT 8'h0f
// field positions
`define CO2RM_RST_BIT 0
`define CO2RM_BUSY_BIT 7
`define CO2RM_ALARM_BIT 6
`define CO2RM_ASEL_BIT 1
`define CO2RM_ISEL_BIT 0
`define CO2RM_PWM_EN_BIT 0
`define CO2RM_COMP_EN_BIT 2
`define CO2RM_PWM_RNG_BIT 3
// fixed upper six bits of the 7-bit slave address
`define CO2RM_DEV_ADDR_HI 6'h34
// concentration limits and threshold step, in ppm
`define CO2RM_SERIAL_MAX 15'h2710
`define CO2RM_PWM_MAX 15'h1388
`define CO2RM_THR_STEP 15'h0064
// reset values of the setting registers
`define CO2RM_RST_MODE 3'h6
`define CO2RM_RST_PRESS 8'h00
`define CO2RM_RST_ALT 8'h00
`define CO2RM_RST_THR_HI 8'h0a
`define CO2RM_RST_THR_LO 8'h09
`define CO2RM_RST_FEAT 8'h00
`endif

// ==== design/co2rm_pkg.sv ====
// types shared by the co2 register bank modules
package co2rm_pkg;
	// serial engine states, one-hot
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_ADDR = 7'h02,
		ST_AACK = 7'h04,
		ST_WBYTE = 7'h08,
		ST_WACK = 7'h10,
		ST_RBYTE = 7'h20,
		ST_RACK = 7'h40
	} co2rm_state_t;
	typedef logic [14:0] co2rm_ppm_t;
	typedef logic [7:0] co2rm_byte_t;
endpackage

// ==== design/co2rm_alarm_if.sv ====
// carrier between register bank and alarm comparator
interface co2rm_alarm_if;
	co2rm_pkg::co2rm_ppm_t ppm; // current result
	co2rm_pkg::co2rm_byte_t upper; // upper threshold, 100 ppm steps
	co2rm_pkg::co2rm_byte_t lower; // lower threshold, 100 ppm steps
	logic update; // new result this cycle
	logic clear; // module soft restart
	logic alarm; // alarm level
	modport core (input ppm, input upper, input lower, input update, input clear, output alarm);
	modport bank (output ppm, output upper, output lower, output update, output clear, input alarm);
endinterface

// ==== design/co2rm_clamp.sv ====
// saturates a concentration at a fixed limit
`include "co2rm_consts.svh"
module co2rm_clamp #(
	parameter logic [14:0] LIMIT = `CO2RM_SERIAL_MAX
) (
	input wire logic [14:0] val_i,
	output logic [14:0] val_o
);
	// pure combinational limit
	assign val_o = (val_i > LIMIT) ? LIMIT : val_i;
endmodule

// ==== design/co2rm_alarm.sv ====
// alarm comparator with hysteresis between two thresholds
`include "co2rm_consts.svh"
module co2rm_alarm (
	input wire logic mclk_i,
	input wire logic rst_i,
	co2rm_alarm_if.core al
);
	logic alarm_q; // alarm state
	logic alarm_d;
	co2rm_pkg::co2rm_ppm_t hi_ppm; // thresholds scaled to ppm
	co2rm_pkg::co2rm_ppm_t lo_ppm;

	// next alarm state: set at upper, drop at lower, hold between
	always_comb
	begin
		hi_ppm = 15'(al.upper) * `CO2RM_THR_STEP;
		lo_ppm = 15'(al.lower) * `CO2RM_THR_STEP;
		alarm_d = alarm_q;
		if (al.clear)
			alarm_d = 1'b0;
		else if (al.update && (al.ppm >= hi_ppm))
			alarm_d = 1'b1;
		else if (al.update && (al.ppm <= lo_ppm))
			alarm_d = 1'b0;
	end

	// state register
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			alarm_q <= 1'b0;
		else
			alarm_q <= alarm_d;
	end

	assign al.alarm = alarm_q;

	// between the thresholds the alarm keeps its level
	hyst_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(al.update && !al.clear && al.ppm > lo_ppm && al.ppm < hi_ppm) |=> $stable(alarm_q))
		else $error("alarm changed inside hysteresis band");
endmodule

// ==== design/co2rm_top.sv ====
// co2 sensor register bank with its serial slave engine
`include "co2rm_consts.svh"
module co2rm_top (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic addr_sel_i,
	input wire logic iface_sel_i,
	input wire logic busy_i,
	input wire logic meas_valid_i,
	input wire logic [14:0] meas_ppm_i,
	input wire logic cal_bg_i,
	input wire logic cal_zero_i,
	output logic alarm_o,
	output logic [14:0] pwm_level_o,
	output logic pwm_enable_o,
	output logic pwm_range_o,
	output logic comp_enable_o,
	output logic [2:0] mode_o,
	output logic [7:0] pressure_o,
	output logic [7:0] altitude_o,
	output logic soft_reset_o,
	output logic cal_bg_o,
	output logic cal_zero_o
);
	// serial engine state
	co2rm_pkg::co2rm_state_t state_q, state_d;
	logic [3:0] bitcnt_q, bitcnt_d; // bits moved in this byte
	co2rm_pkg::co2rm_byte_t shift_q, shift_d; // in/out shifter
	logic rw_q, rw_d; // transfer direction
	logic first_q, first_d; // next written byte is the pointer
	logic mack_q, mack_d; // master acked last read byte
	logic oe_q, oe_d; // pull sda low
	logic scl_q, sda_q; // previous pin levels
	logic sda_zero_q; // driven level, open drain
	// strobes from the engine to the bank
	logic ptr_stb, wr_stb, rd_stb;
	logic [6:0] dev_addr;
	// edge and condition decode
	logic scl_rise, scl_fall, start_c, stop_c;

	// register bank state
	co2rm_pkg::co2rm_byte_t ptr_q, ptr_d; // register pointer
	logic [2:0] mode_q, mode_d;
	co2rm_pkg::co2rm_byte_t press_q, press_d; // pressure setting
	co2rm_pkg::co2rm_byte_t alt_q, alt_d; // altitude setting
	co2rm_pkg::co2rm_byte_t thr_hi_q, thr_hi_d; // upper alarm threshold
	co2rm_pkg::co2rm_byte_t thr_lo_q, thr_lo_d; // lower alarm threshold
	logic pwm_en_q, pwm_en_d, comp_en_q, comp_en_d, pwm_rng_q, pwm_rng_d;
	// feature reset byte held as a constant so single bits can be picked
	localparam logic [7:0] FEAT_RST = `CO2RM_RST_FEAT;
	co2rm_pkg::co2rm_ppm_t result_q, result_d;
	logic [6:0] hi_snap_q, hi_snap_d; // high bits frozen at low read
	logic snap_vld_q, snap_vld_d;
	logic soft_q, soft_d; // one-cycle restart pulse
	co2rm_pkg::co2rm_ppm_t pwm_q, pwm_d;
	logic cal_bg_q, cal_bg_d, cal_zero_q, cal_zero_d;
	logic cal_bg_prev_q, cal_zero_prev_q;
	co2rm_pkg::co2rm_byte_t rd_data; // byte at the pointer
	co2rm_pkg::co2rm_byte_t status; // live status byte
	co2rm_pkg::co2rm_ppm_t meas_clamped, pwm_clamped;

	co2rm_alarm_if al_if ();

	// concentration never reported past serial full scale
	co2rm_clamp #(.LIMIT(`CO2RM_SERIAL_MAX)) u_serial_clamp (
		.val_i(meas_ppm_i),
		.val_o(meas_clamped)
	);
	// pwm level saturates lower than the serial range
	co2rm_clamp #(.LIMIT(`CO2RM_PWM_MAX)) u_pwm_clamp (
		.val_i(result_q),
		.val_o(pwm_clamped)
	);
	co2rm_alarm u_alarm (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.al(al_if)
	);

	// alarm judges the incoming result, so it moves on the same edge as the result
	assign al_if.ppm = meas_clamped;
	assign al_if.upper = thr_hi_q;
	assign al_if.lower = thr_lo_q;
	assign al_if.update = meas_valid_i && !soft_q;
	assign al_if.clear = soft_q;

	// address lsb follows the select pin, the upper six bits are fixed
	assign dev_addr = {`CO2RM_DEV_ADDR_HI, addr_sel_i};
	assign scl_rise = scl_i && !scl_q;
	assign scl_fall = !scl_i && scl_q;
	// sda moving while scl is high marks start or stop
	assign start_c = scl_i && scl_q && sda_q && !sda_i;
	assign stop_c = scl_i && scl_q && !sda_q && sda_i;

	// engine next state; start and stop win over bit activity
	always_comb
	begin
		state_d = state_q;
		bitcnt_d = bitcnt_q;
		shift_d = shift_q;
		rw_d = rw_q;
		first_d = first_q;
		mack_d = mack_q;
		oe_d = oe_q;
		ptr_stb = 1'b0;
		wr_stb = 1'b0;
		rd_stb = 1'b0;
		if (start_c)
		begin
			state_d = co2rm_pkg::ST_ADDR;
			bitcnt_d = 4'h0;
			first_d = 1'b1;
			oe_d = 1'b0;
		end
		else if (stop_c)
		begin
			state_d = co2rm_pkg::ST_IDLE;
			oe_d = 1'b0;
		end
		else
		begin
			case (state_q)
				co2rm_pkg::ST_IDLE:
					oe_d = 1'b0;
				co2rm_pkg::ST_ADDR, co2rm_pkg::ST_WBYTE:
				begin
					// sample on rise, act after the eighth bit falls
					if (scl_rise)
					begin
						shift_d = {shift_q[6:0], sda_i};
						bitcnt_d = bitcnt_q + 4'h1;
					end
					else if (scl_fall && bitcnt_q == 4'h8)
					begin
						if (state_q == co2rm_pkg::ST_ADDR)
						begin
							// other addresses are ignored until next start
							if (shift_q[7:1] == dev_addr)
							begin
								state_d = co2rm_pkg::ST_AACK;
								rw_d = shift_q[0];
								oe_d = 1'b1;
							end
							else
								state_d = co2rm_pkg::ST_IDLE;
						end
						else
						begin
							state_d = co2rm_pkg::ST_WACK;
							oe_d = 1'b1;
							ptr_stb = first_q;
							wr_stb = !first_q;
							first_d = 1'b0;
						end
					end
				end
				co2rm_pkg::ST_AACK, co2rm_pkg::ST_WACK:
				begin
					// ack bit ends at the falling edge after it
					if (scl_fall)
					begin
						bitcnt_d = 4'h0;
						if (state_q == co2rm_pkg::ST_AACK && rw_q)
						begin
							state_d = co2rm_pkg::ST_RBYTE;
							shift_d = rd_data;
							rd_stb = 1'b1;
							oe_d = !rd_data[7];
						end
						else
						begin
							state_d = co2rm_pkg::ST_WBYTE;
							oe_d = 1'b0;
						end
					end
				end
				co2rm_pkg::ST_RBYTE:
				begin
					// next bit goes out on each falling edge
					if (scl_fall)
					begin
						if (bitcnt_q == 4'h7)
						begin
							state_d = co2rm_pkg::ST_RACK;
							oe_d = 1'b0;
						end
						else
						begin
							shift_d = {shift_q[6:0], 1'b0};
							oe_d = !shift_q[6];
							bitcnt_d = bitcnt_q + 4'h1;
						end
					end
				end
				co2rm_pkg::ST_RACK:
				begin
					// a nack ends the read; wait for stop
					if (scl_rise)
						mack_d = !sda_i;
					else if (scl_fall)
					begin
						bitcnt_d = 4'h0;
						if (mack_q)
						begin
							state_d = co2rm_pkg::ST_RBYTE;
							shift_d = rd_data;
							rd_stb = 1'b1;
							oe_d = !rd_data[7];
						end
						else
							state_d = co2rm_pkg::ST_IDLE;
					end
				end
				default:
				begin
					state_d = co2rm_pkg::ST_IDLE;
					oe_d = 1'b0;
				end
			endcase
		end
	end

	// engine registers
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			state_q <= co2rm_pkg::ST_IDLE;
			bitcnt_q <= 4'h0;
			shift_q <= 8'h00;
			rw_q <= 1'b0;
			first_q <= 1'b0;
			mack_q <= 1'b0;
			oe_q <= 1'b0;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			sda_zero_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			bitcnt_q <= bitcnt_d;
			shift_q <= shift_d;
			rw_q <= rw_d;
			first_q <= first_d;
			mack_q <= mack_d;
			oe_q <= oe_d;
			scl_q <= scl_i;
			sda_q <= sda_i;
			sda_zero_q <= 1'b0;
		end
	end

	// status byte reflects live state and pin levels
	always_comb
	begin
		status = 8'h00;
		status[`CO2RM_BUSY_BIT] = busy_i;
		status[`CO2RM_ALARM_BIT] = al_if.alarm;
		status[`CO2RM_ASEL_BIT] = addr_sel_i;
		status[`CO2RM_ISEL_BIT] = iface_sel_i;
	end

	// read mux; unmapped and write-only offsets read zero
	always_comb
	begin
		case (ptr_q)
			`CO2RM_OFF_MODE: rd_data = {5'h00, mode_q};
			`CO2RM_OFF_STAT: rd_data = status;
			`CO2RM_OFF_DLO: rd_data = result_q[7:0];
			`CO2RM_OFF_DHI: rd_data = {1'b0, snap_vld_q ? hi_snap_q : result_q[14:8]};
			`CO2RM_OFF_PRESS: rd_data = press_q;
			`CO2RM_OFF_ALT: rd_data = alt_q;
			`CO2RM_OFF_THR_HI: rd_data = thr_hi_q;
			`CO2RM_OFF_THR_LO: rd_data = thr_lo_q;
			`CO2RM_OFF_FEAT: rd_data = {4'h0, pwm_rng_q, comp_en_q, 1'b0, pwm_en_q};
			default: rd_data = 8'h00;
		endcase
	end

	// bank next values; pointer advances after every data byte
	always_comb
	begin
		ptr_d = ptr_q;
		mode_d = mode_q;
		press_d = press_q;
		alt_d = alt_q;
		thr_hi_d = thr_hi_q;
		thr_lo_d = thr_lo_q;
		pwm_en_d = pwm_en_q;
		comp_en_d = comp_en_q;
		pwm_rng_d = pwm_rng_q;
		result_d = result_q;
		hi_snap_d = hi_snap_q;
		snap_vld_d = snap_vld_q;
		soft_d = 1'b0;
		if (ptr_stb)
			ptr_d = shift_q;
		else if (wr_stb || rd_stb)
			ptr_d = ptr_q + 8'h01;
		if (wr_stb)
		begin
			case (ptr_q)
				`CO2RM_OFF_RST: soft_d = shift_q[`CO2RM_RST_BIT];
				`CO2RM_OFF_MODE: mode_d = shift_q[2:0];
				`CO2RM_OFF_PRESS: press_d = shift_q;
				`CO2RM_OFF_ALT: alt_d = shift_q;
				`CO2RM_OFF_THR_HI: thr_hi_d = shift_q;
				`CO2RM_OFF_THR_LO: thr_lo_d = shift_q;
				`CO2RM_OFF_FEAT:
				begin
					pwm_en_d = shift_q[`CO2RM_PWM_EN_BIT];
					comp_en_d = shift_q[`CO2RM_COMP_EN_BIT];
					pwm_rng_d = shift_q[`CO2RM_PWM_RNG_BIT];
				end
				default: ;
			endcase
		end
		// freeze high bits so a two-byte read is never torn
		if (rd_stb && ptr_q == `CO2RM_OFF_DLO)
		begin
			hi_snap_d = result_q[14:8];
			snap_vld_d = 1'b1;
		end
		else if (rd_stb && ptr_q == `CO2RM_OFF_DHI)
			snap_vld_d = 1'b0;
		if (meas_valid_i)
			result_d = meas_clamped;
		// restart drops volatile state, settings stay
		if (soft_q)
		begin
			result_d = 15'h0000;
			snap_vld_d = 1'b0;
			ptr_d = 8'h00;
		end
	end

	// pwm level, calibration pulses from rising requests
	always_comb
	begin
		pwm_d = pwm_en_q ? pwm_clamped : 15'h0000;
		cal_bg_d = cal_bg_i && !cal_bg_prev_q && !busy_i;
		cal_zero_d = cal_zero_i && !cal_zero_prev_q && !busy_i;
	end

	// bank registers; settings take defaults only at power-on reset
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			ptr_q <= 8'h00;
			mode_q <= `CO2RM_RST_MODE;
			press_q <= `CO2RM_RST_PRESS;
			alt_q <= `CO2RM_RST_ALT;
			thr_hi_q <= `CO2RM_RST_THR_HI;
			thr_lo_q <= `CO2RM_RST_THR_LO;
			pwm_en_q <= FEAT_RST[`CO2RM_PWM_EN_BIT];
			comp_en_q <= FEAT_RST[`CO2RM_COMP_EN_BIT];
			pwm_rng_q <= FEAT_RST[`CO2RM_PWM_RNG_BIT];
			result_q <= 15'h0000;
			hi_snap_q <= 7'h00;
			snap_vld_q <= 1'b0;
			soft_q <= 1'b0;
			pwm_q <= 15'h0000;
			cal_bg_q <= 1'b0;
			cal_zero_q <= 1'b0;
			cal_bg_prev_q <= 1'b0;
			cal_zero_prev_q <= 1'b0;
		end
		else
		begin
			ptr_q <= ptr_d;
			mode_q <= mode_d;
			press_q <= press_d;
			alt_q <= alt_d;
			thr_hi_q <= thr_hi_d;
			thr_lo_q <= thr_lo_d;
			pwm_en_q <= pwm_en_d;
			comp_en_q <= comp_en_d;
			pwm_rng_q <= pwm_rng_d;
			result_q <= result_d;
			hi_snap_q <= hi_snap_d;
			snap_vld_q <= snap_vld_d;
			soft_q <= soft_d;
			pwm_q <= pwm_d;
			cal_bg_q <= cal_bg_d;
			cal_zero_q <= cal_zero_d;
			cal_bg_prev_q <= cal_bg_i;
			cal_zero_prev_q <= cal_zero_i;
		end
	end

	// outputs straight from flops
	assign sda_o = sda_zero_q;
	assign sda_oe_o = oe_q;
	assign alarm_o = al_if.alarm;
	assign pwm_level_o = pwm_q;
	assign pwm_enable_o = pwm_en_q;
	assign pwm_range_o = pwm_rng_q;
	assign comp_enable_o = comp_en_q;
	assign mode_o = mode_q;
	assign pressure_o = press_q;
	assign altitude_o = alt_q;
	assign soft_reset_o = soft_q;
	assign cal_bg_o = cal_bg_q;
	assign cal_zero_o = cal_zero_q;

	// low byte read loads result bits into the shifter
	low_byte_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(rd_stb && ptr_q == `CO2RM_OFF_DLO && !meas_valid_i) |=> shift_q == result_q[7:0])
		else $error("low byte read mismatch");
	high_byte_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(rd_stb && ptr_q == `CO2RM_OFF_DHI) |=> !shift_q[7])
		else $error("high byte top bit not zero");
	status_bits_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(rd_stb && ptr_q == `CO2RM_OFF_STAT) |=> shift_q == {$past(busy_i), $past(alarm_o),
		4'h0, $past(addr_sel_i), $past(iface_sel_i)})
		else $error("status byte wrong");
	thr_write_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(wr_stb && ptr_q == `CO2RM_OFF_THR_HI) |=> thr_hi_q == $past(shift_q)
		##1 ptr_q != `CO2RM_OFF_THR_HI)
		else $error("upper threshold not stored");
	lo_write_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(wr_stb && ptr_q == `CO2RM_OFF_THR_LO) |=> thr_lo_q == $past(shift_q))
		else $error("lower threshold not stored");
	feat_write_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(wr_stb && ptr_q == `CO2RM_OFF_FEAT) |=> {pwm_rng_q, comp_en_q, pwm_en_q} ==
		{$past(shift_q[3]), $past(shift_q[2]), $past(shift_q[0])})
		else $error("feature bits not stored");
	serial_range_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		meas_valid_i && !soft_q |=> result_q <= `CO2RM_SERIAL_MAX)
		else $error("result beyond serial range");
	pwm_sat_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		pwm_en_q |=> pwm_level_o <= `CO2RM_PWM_MAX && (pwm_level_o != 15'h0000
		|| result_q == 15'h0000 || $past(result_q) == 15'h0000 || !$past(pwm_en_q)))
		else $error("pwm level not saturated");
	addr_ack_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(state_q == co2rm_pkg::ST_ADDR && scl_fall && bitcnt_q == 4'h8 && !start_c && !stop_c
		&& shift_q[7:1] == dev_addr) |=> sda_oe_o && state_q == co2rm_pkg::ST_AACK)
		else $error("own address not acked");
	soft_pulse_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(wr_stb && ptr_q == `CO2RM_OFF_RST && shift_q[0]) |=> soft_reset_o ##1 !soft_reset_o
		&& result_q == 15'h0000)
		else $error("soft restart pulse wrong");
	nv_keep_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		soft_q |=> $stable(thr_hi_q) && $stable(thr_lo_q) && $stable(mode_q) && $stable(press_q))
		else $error("settings lost on restart");
endmodule

// ==== test/co2rm_i2c_master.sv ====
// serial bus master model for the register bank
module co2rm_i2c_master (
	input wire logic mclk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_oe_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// idle bus: scl driven high, sda released so the pull-up holds it high
	initial
	begin
		scl_o = 1'b1;
		sda_oe_o = 1'b0;
	end
	// waits n edges, then steps off the edge
	task automatic tick(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	// data moves one mclk after scl fell, never on an scl edge
	task automatic bit_out(input logic b);
		tick(1);
		sda_oe_o = !b;
		tick(3);
		scl_o = 1'b1;
		tick(4);
		scl_o = 1'b0;
	endtask
	// released line sampled mid high phase
	task automatic bit_in(output logic b);
		tick(1);
		sda_oe_o = 1'b0;
		tick(3);
		scl_o = 1'b1;
		tick(2);
		b = sda_i;
		tick(2);
		scl_o = 1'b0;
	endtask
	// start or repeated start: sda falls while scl high
	task automatic start();
		tick(1);
		sda_oe_o = 1'b0;
		tick(3);
		scl_o = 1'b1;
		tick(4);
		sda_oe_o = 1'b1;
		tick(4);
		scl_o = 1'b0;
	endtask
	// stop: sda rises while scl high
	task automatic stop();
		tick(1);
		sda_oe_o = 1'b1;
		tick(3);
		scl_o = 1'b1;
		tick(4);
		sda_oe_o = 1'b0;
		tick(4);
	endtask
	// byte out msb first, slave ack back (0 = ack)
	task automatic put_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) bit_out(b[i]);
		bit_in(ack);
	endtask
	// byte in msb first, then master ack or nack
	task automatic get_byte(input logic nack, output logic [7:0] b);
		for (int i = 7; i >= 0; i--) bit_in(b[i]);
		bit_out(nack);
	endtask
endmodule

// ==== test/co2rm_tb.sv ====
// self-checking bench for the co2 register bank
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk_i = 1'b0; // 10 MHz
	logic rst_i = 1'b1;
	logic addr_sel_i = 1'b0;
	logic iface_sel_i = 1'b0;
	logic busy_i = 1'b0;
	logic meas_valid_i = 1'b0;
	logic [14:0] meas_ppm_i = 15'h0000;
	logic cal_bg_i = 1'b0;
	logic cal_zero_i = 1'b0;
	logic scl_i, m_oe, sda_o, sda_oe_o, alarm_o, pwm_enable_o, pwm_range_o, comp_enable_o;
	logic soft_reset_o, cal_bg_o, cal_zero_o;
	logic [14:0] pwm_level_o;
	logic [2:0] mode_o;
	logic [7:0] pressure_o, altitude_o;
	int n_fail = 0;
	int n_tests = 0;
	int n_srst = 0;
	int n_bg = 0;
	int n_zero = 0;
	// open-drain wire, pulled up unless a party pulls low
	wire logic sda_i = !(m_oe || (sda_oe_o && !sda_o));
	co2rm_i2c_master m_u (.mclk_i, .sda_i, .scl_o(scl_i), .sda_oe_o(m_oe));
	co2rm_top dut_u (.mclk_i, .rst_i, .scl_i, .sda_i, .sda_o, .sda_oe_o, .addr_sel_i,
		.iface_sel_i, .busy_i, .meas_valid_i, .meas_ppm_i, .cal_bg_i, .cal_zero_i, .alarm_o,
		.pwm_level_o, .pwm_enable_o, .pwm_range_o, .comp_enable_o, .mode_o, .pressure_o,
		.altitude_o, .soft_reset_o, .cal_bg_o, .cal_zero_o);
	// clock
	initial
	begin
		forever #50 mclk_i = !mclk_i;
	end
	// pulse counters, single-cycle outputs seen on every edge
	always @(posedge mclk_i)
	begin
		n_srst <= n_srst + int'(soft_reset_o === 1'b1);
		n_bg <= n_bg + int'(cal_bg_o === 1'b1);
		n_zero <= n_zero + int'(cal_zero_o === 1'b1);
	end
	task automatic tick(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	task automatic check(input logic [14:0] seen, input logic [14:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		if (n_fail == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// byte that the slave must acknowledge
	task automatic send(input logic [7:0] b);
		logic ack;
		m_u.put_byte(b, ack);
		check(15'(ack), 15'h0000);
	endtask
	task automatic write_reg(input logic [7:0] ptr, input logic [7:0] dat);
		m_u.start();
		send({6'h34, addr_sel_i, 1'b0});
		send(ptr);
		send(dat);
		m_u.stop();
	endtask
	// pointer write, repeated start, n bytes back (1 or 2)
	task automatic read_regs(input logic [7:0] ptr, input int n, output logic [7:0] b0,
		output logic [7:0] b1);
		b1 = 8'h00;
		m_u.start();
		send({6'h34, addr_sel_i, 1'b0});
		send(ptr);
		m_u.start();
		send({6'h34, addr_sel_i, 1'b1});
		m_u.get_byte(n == 1, b0);
		if (n == 2)
			m_u.get_byte(1'b1, b1);
		m_u.stop();
	endtask
	task automatic expect_reg(input logic [7:0] ptr, input logic [7:0] exp);
		logic [7:0] b0, b1;
		read_regs(ptr, 1, b0, b1);
		check(15'(b0), 15'(exp));
	endtask
	// one new result, then let it settle
	task automatic meas(input logic [14:0] v);
		meas_ppm_i = v;
		meas_valid_i = 1'b1;
		tick(1);
		meas_valid_i = 1'b0;
		tick(2);
	endtask
	// watchdog, main sequence needs well under 2 ms
	initial
	begin
		#5000000;
		n_fail++;
		print_verdict();
	end
	// main sequence
	initial
	begin
		logic [7:0] lo, hi;
		logic ack;
		tick(3);
		rst_i = 1'b0;
		tick(2);
		check(15'(mode_o), 15'h0006);
		check(15'(pressure_o), 15'h0000);
		check(15'(altitude_o), 15'h0000);
		expect_reg(8'h0c, 8'h0a);
		expect_reg(8'h0d, 8'h09);
		expect_reg(8'h0f, 8'h00);
		// pin levels in status, address follows the select pin
		addr_sel_i = 1'b1;
		iface_sel_i = 1'b1;
		busy_i = 1'b1;
		tick(2);
		expect_reg(8'h02, 8'h83);
		m_u.start();
		m_u.put_byte(8'hd0, ack);
		check(15'(ack), 15'h0001);
		m_u.stop();
		addr_sel_i = 1'b0;
		iface_sel_i = 1'b0;
		busy_i = 1'b0;
		tick(2);
		expect_reg(8'h02, 8'h00);
		write_reg(8'h01, 8'h05);
		check(15'(mode_o), 15'h0005);
		write_reg(8'h01, 8'h06);
		check(15'(mode_o), 15'h0006);
		write_reg(8'h09, 8'ha5);
		write_reg(8'h0a, 8'h5a);
		check(15'(pressure_o), 15'h00a5);
		check(15'(altitude_o), 15'h005a);
		// results: split bytes, clamp, pwm saturation
		meas(15'h0659);
		check(pwm_level_o, 15'h0000);
		read_regs(8'h03, 2, lo, hi);
		check(15'(lo), 15'h0059);
		check(15'(hi), 15'h0006);
		meas(15'h7fff);
		read_regs(8'h03, 2, lo, hi);
		check(15'({hi, lo}), 15'h2710);
		write_reg(8'h0f, 8'h0d);
		check(15'({pwm_range_o, comp_enable_o, pwm_enable_o}), 15'h0007);
		check(pwm_level_o, 15'h1388);
		meas(15'h0bb8);
		check(pwm_level_o, 15'h0bb8);
		// alarm hysteresis, default then moved thresholds
		meas(15'h03e8);
		check(15'(alarm_o), 15'h0001);
		meas(15'h03b6);
		check(15'(alarm_o), 15'h0001);
		meas(15'h0384);
		check(15'(alarm_o), 15'h0000);
		write_reg(8'h0c, 8'h14);
		write_reg(8'h0d, 8'h0a);
		meas(15'h05dc);
		check(15'(alarm_o), 15'h0000);
		meas(15'h07d0);
		check(15'(alarm_o), 15'h0001);
		meas(15'h044c);
		check(15'(alarm_o), 15'h0001);
		meas(15'h03e8);
		check(15'(alarm_o), 15'h0000);
		meas(15'h07d0);
		expect_reg(8'h02, 8'h40);
		// read-only result ignores writes
		write_reg(8'h03, 8'hff);
		expect_reg(8'h03, 8'hd0);
		// soft restart keeps settings, drops result and alarm
		write_reg(8'h00, 8'h01);
		check(15'(n_srst), 15'h0001);
		check(15'(alarm_o), 15'h0000);
		read_regs(8'h03, 2, lo, hi);
		check(15'({hi, lo}), 15'h0000);
		expect_reg(8'h00, 8'h00);
		expect_reg(8'h0c, 8'h14);
		check(15'({pwm_enable_o, mode_o}), 15'h000e);
		// calibration pulses, blocked while busy
		cal_bg_i = 1'b1;
		tick(4);
		cal_bg_i = 1'b0;
		busy_i = 1'b1;
		cal_zero_i = 1'b1;
		tick(4);
		cal_zero_i = 1'b0;
		busy_i = 1'b0;
		tick(1);
		cal_zero_i = 1'b1;
		tick(4);
		cal_zero_i = 1'b0;
		tick(2);
		check(15'(n_bg), 15'h0001);
		check(15'(n_zero), 15'h0001);
		// second power-on reset loads defaults
		rst_i = 1'b1;
		tick(2);
		rst_i = 1'b0;
		tick(2);
		check(15'({pwm_enable_o, mode_o}), 15'h0006);
		expect_reg(8'h0c, 8'h0a);
		print_verdict();
	end
endmodule
